/* File: verilog/irps_pkg.sv */
// Constants and types shared by the I2C register port of the video link switch.
// Assumes one 20 MHz system clock; all pins are synchronised before use.
// What this block does
// - Restore pin low returns every register to its default, at any time.
// - Answer seven-bit address 10010 plus two strap bits, sent MSB first.
// - Write direction bit zero after address; device acknowledges.
// - Eight-bit pointer follows address, MSB first; device acknowledges and latches it.
// - One data byte after the pointer is stored and acknowledged.
// - Repeated start after a write begins a new transfer without stop.
// - Write then repeated start read returns the register the pointer selected.
// - Read: write pointer, repeated start, address with direction one, acknowledge.
// - Read drives eight register bits onto the data line, MSB first.
// - Controller acknowledge of a read byte makes the device send the next.
// - Controller NACK then stop ends a read; device releases data line.
// - Channel register bit 2 picks pins (zero) or channel field (one).
// - Channel field 00, 01, 10, 11 selects inputs A, B, C, D.
// - Output register bit 3 picks enable pin (zero) or enable bit (one).
// - Enable bit, when in force, disables output at zero, enables at one.
// - Output register bit 1 sets drive current: 10 mA or 20 mA.
// - Output register bit 0 at zero turns output termination off.
// - Output register bit 0 at one turns output termination on.
package irps_pkg;
   // Target address
   localparam logic [4:0] ADDR_UPPER = 5'h12;
   // Register offsets
   localparam logic [7:0] CHAN_SEL_OFS = 8'h00;
   localparam logic [7:0] OUT_CTL_OFS = 8'h01;
   // Values after reset and implemented bits
   localparam logic [7:0] CHAN_SEL_RST = 8'h00;
   localparam logic [7:0] OUT_CTL_RST = 8'h07;
   localparam logic [7:0] CHAN_SEL_MASK = 8'h07;
   localparam logic [7:0] OUT_CTL_MASK = 8'h0f;
   // Field positions
   localparam int INPUT_CHOICE_SOURCE_BIT = 2;
   localparam int OUT_EN_SRC_BIT = 3;
   localparam int OUT_EN_BIT = 2;
   localparam int OUT_CUR_BIT = 1;
   localparam int OUT_TERM_BIT = 0;
   // Bit counter end and acknowledge phases
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] PH_WAIT = 2'h0;
   localparam logic [1:0] PH_HELD = 2'h1;
   localparam logic [1:0] PH_SAMPLED = 2'h2;
   // Pin synchroniser value after reset: scl, sda, restore high
   localparam logic [7:0] PIN_IDLE = 8'he0;
   // Serial port states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK,
      ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_IGNORE
   } irps_state_t;
endpackage

/* File: verilog/irps_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are slow levels; there is no glitch filter, so any level seen at a clock edge passes.
`timescale 1ns/1ns
`default_nettype none
module irps_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync;

   if (WIDTH < 1) begin : g_chk
      $error("irps_sync needs WIDTH of at least 1");
   end

   // First stage is read only by the second
   always_comb begin
      next_meta = async_i;
      next_sync = meta;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         meta <= INIT;
         sync_o <= INIT;
      end else begin
         meta <= next_meta;
         sync_o <= next_sync;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/irps_regs.sv */
// Channel select and output control registers with their pin/register muxes.
// Assumes write strobe, pointer and data come from the serial port on the same clock.
`timescale 1ns/1ns
`default_nettype none
module irps_regs (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Synchronised restore pin, active low
   input wire logic restore_n_i,
   // Register access
   input wire logic wr_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] rd_data_o,
   // Synchronised parallel pins
   input wire logic [1:0] sel_pins_i,
   input wire logic en_pin_i,
   // Link controls
   output logic [1:0] active_input_o,
   output logic output_enable_o,
   output logic output_current_level_o,
   output logic output_termination_on_o
);
   logic [7:0] chan_sel;
   logic [7:0] out_ctl;
   logic [7:0] next_chan_sel;
   logic [7:0] next_out_ctl;
   logic [1:0] next_active;
   logic next_enable;

   // Restore beats a write in the same cycle
   always_comb begin
      next_chan_sel = chan_sel;
      next_out_ctl = out_ctl;
      if (!restore_n_i) begin
         next_chan_sel = irps_pkg::CHAN_SEL_RST;
         next_out_ctl = irps_pkg::OUT_CTL_RST;
      end else if (wr_en_i) begin
         if (addr_i == irps_pkg::CHAN_SEL_OFS) begin
            next_chan_sel = wr_data_i & irps_pkg::CHAN_SEL_MASK;
         end
         if (addr_i == irps_pkg::OUT_CTL_OFS) begin
            next_out_ctl = wr_data_i & irps_pkg::OUT_CTL_MASK;
         end
      end
      // Source muxes
      if (chan_sel[irps_pkg::INPUT_CHOICE_SOURCE_BIT]) begin
         next_active = chan_sel[1:0];
      end else begin
         next_active = sel_pins_i;
      end
      if (out_ctl[irps_pkg::OUT_EN_SRC_BIT]) begin
         next_enable = out_ctl[irps_pkg::OUT_EN_BIT];
      end else begin
         next_enable = en_pin_i;
      end
   end

   // Unmapped pointers read as zero
   assign rd_data_o = (addr_i == irps_pkg::CHAN_SEL_OFS) ? chan_sel :
                      (addr_i == irps_pkg::OUT_CTL_OFS) ? out_ctl : 8'h00;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         chan_sel <= irps_pkg::CHAN_SEL_RST;
         out_ctl <= irps_pkg::OUT_CTL_RST;
         active_input_o <= 2'h0;
         output_enable_o <= 1'b0;
         output_current_level_o <= irps_pkg::OUT_CTL_RST[irps_pkg::OUT_CUR_BIT];
         output_termination_on_o <= irps_pkg::OUT_CTL_RST[irps_pkg::OUT_TERM_BIT];
      end else begin
         chan_sel <= next_chan_sel;
         out_ctl <= next_out_ctl;
         active_input_o <= next_active;
         output_enable_o <= next_enable;
         output_current_level_o <= out_ctl[irps_pkg::OUT_CUR_BIT];
         output_termination_on_o <= out_ctl[irps_pkg::OUT_TERM_BIT];
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_restore;
      !restore_n_i |=> chan_sel == irps_pkg::CHAN_SEL_RST && out_ctl == irps_pkg::OUT_CTL_RST;
   endproperty
   a_restore: assert property (p_restore) else $error("restore missed");
   property p_store;
      restore_n_i && wr_en_i && addr_i == irps_pkg::OUT_CTL_OFS |=>
         out_ctl == ($past(wr_data_i) & irps_pkg::OUT_CTL_MASK);
   endproperty
   a_store: assert property (p_store) else $error("write not stored");
   property p_pin_sel;
      !chan_sel[irps_pkg::INPUT_CHOICE_SOURCE_BIT] |=> active_input_o == $past(sel_pins_i);
   endproperty
   a_pin_sel: assert property (p_pin_sel) else $error("pin select ignored");
   property p_reg_sel;
      chan_sel[irps_pkg::INPUT_CHOICE_SOURCE_BIT] |=> active_input_o == $past(chan_sel[1:0]);
   endproperty
   a_reg_sel: assert property (p_reg_sel) else $error("channel field ignored");
   property p_enable;
      ##1 output_enable_o == ($past(out_ctl[irps_pkg::OUT_EN_SRC_BIT]) ?
         $past(out_ctl[irps_pkg::OUT_EN_BIT]) : $past(en_pin_i));
   endproperty
   a_enable: assert property (p_enable) else $error("enable source wrong");
   property p_drive;
      ##1 output_current_level_o == $past(out_ctl[1]) && output_termination_on_o == $past(out_ctl[0]);
   endproperty
   a_drive: assert property (p_drive) else $error("drive controls wrong");
   property p_unused;
      chan_sel[7:3] == 5'h00 && out_ctl[7:4] == 4'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits set");
endmodule
`default_nettype wire

/* File: verilog/irps_top.sv */
// Top of the I2C register port: serial target state machine and register block.
// Assumes SCL and SDA are open-drain bus lines far slower than the 20 MHz clock;
// no clock stretching is done, so the controller sets the bit rate alone.
`timescale 1ns/1ns
`default_nettype none
module irps_top (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Serial bus, data line open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Address straps and restore pin
   input wire logic [1:0] addr_strap_i,
   input wire logic restore_defaults_n_i,
   // Parallel control pins
   input wire logic [1:0] chan_select_pins_i,
   input wire logic output_enable_pin_i,
   // Link controls
   output logic [1:0] active_input_o,
   output logic output_enable_o,
   output logic output_current_level_o,
   output logic output_termination_on_o
);
   logic [7:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic restore_s;
   logic [1:0] sel_s;
   logic en_s;
   logic [1:0] strap_s;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic quiet;
   irps_pkg::irps_state_t state;
   irps_pkg::irps_state_t next_state;
   logic [2:0] bit_cnt;
   logic [2:0] next_cnt;
   logic [7:0] shreg;
   logic [7:0] next_sh;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic [1:0] ack_ph;
   logic [1:0] next_ph;
   logic m_ack;
   logic next_m_ack;
   logic next_oe;
   logic wr_en;
   logic next_wr;
   logic [7:0] rd_data;

   // Address compare against the fixed upper bits and the straps
   function automatic logic irps_addr_hit(input logic [6:0] addr, input logic [1:0] strap);
      return addr == {irps_pkg::ADDR_UPPER, strap};
   endfunction

   // All pins cross into the clock domain together
   irps_sync #(
      .WIDTH(8),
      .INIT(irps_pkg::PIN_IDLE)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .async_i({scl_i, sda_i, restore_defaults_n_i, chan_select_pins_i,
                output_enable_pin_i, addr_strap_i}),
      .sync_o(pins_s)
   );

   assign scl_s = pins_s[7];
   assign sda_s = pins_s[6];
   assign restore_s = pins_s[5];
   assign sel_s = pins_s[4:3];
   assign en_s = pins_s[2];
   assign strap_s = pins_s[1:0];

   // Bus events from synchronised levels only
   assign scl_rise = scl_s && !scl_q;
   assign scl_fall = !scl_s && scl_q;
   assign start_det = scl_s && scl_q && sda_q && !sda_s;
   assign stop_det = scl_s && scl_q && !sda_q && sda_s;
   assign quiet = !start_det && !stop_det;

   // Serial target; SDA changes only after a SCL fall, so our own
   // drive can never look like a start or stop
   always_comb begin
      next_state = state;
      next_cnt = bit_cnt;
      next_sh = shreg;
      next_ptr = ptr;
      next_ph = ack_ph;
      next_m_ack = m_ack;
      next_oe = sda_oe_o;
      next_wr = 1'b0;
      if (stop_det) begin
         next_state = irps_pkg::ST_IDLE;
         next_oe = 1'b0;
         next_ph = irps_pkg::PH_WAIT;
      end else if (start_det) begin
         // Repeated start is taken in any state, pointer kept
         next_state = irps_pkg::ST_ADDR;
         next_cnt = 3'h0;
         next_oe = 1'b0;
         next_ph = irps_pkg::PH_WAIT;
      end else begin
         case (state)
            irps_pkg::ST_IDLE: begin
               next_oe = 1'b0;
            end
            irps_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  next_sh = {shreg[6:0], sda_s};
                  next_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == irps_pkg::BIT_LAST) begin
                     if (irps_addr_hit(shreg[6:0], strap_s)) begin
                        next_state = irps_pkg::ST_AACK;
                     end else begin
                        next_state = irps_pkg::ST_IGNORE;
                     end
                  end
               end
            end
            irps_pkg::ST_AACK: begin
               // Direction bit sits in the low bit of the shifter
               if (scl_fall) begin
                  if (ack_ph == irps_pkg::PH_WAIT) begin
                     next_oe = 1'b1;
                     next_ph = irps_pkg::PH_HELD;
                  end else begin
                     next_ph = irps_pkg::PH_WAIT;
                     next_cnt = 3'h0;
                     if (shreg[0]) begin
                        next_sh = rd_data;
                        next_oe = !rd_data[7];
                        next_state = irps_pkg::ST_RDATA;
                     end else begin
                        next_oe = 1'b0;
                        next_state = irps_pkg::ST_PTR;
                     end
                  end
               end
            end
            irps_pkg::ST_PTR: begin
               if (scl_rise) begin
                  next_sh = {shreg[6:0], sda_s};
                  next_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == irps_pkg::BIT_LAST) begin
                     next_ptr = {shreg[6:0], sda_s};
                     next_state = irps_pkg::ST_PACK;
                  end
               end
            end
            irps_pkg::ST_PACK, irps_pkg::ST_WACK: begin
               if (scl_fall) begin
                  if (ack_ph == irps_pkg::PH_WAIT) begin
                     next_oe = 1'b1;
                     next_ph = irps_pkg::PH_HELD;
                  end else begin
                     next_oe = 1'b0;
                     next_ph = irps_pkg::PH_WAIT;
                     next_cnt = 3'h0;
                     next_state = irps_pkg::ST_WDATA;
                  end
               end
            end
            irps_pkg::ST_WDATA: begin
               // Pointer stays put so a following read sees this register
               if (scl_rise) begin
                  next_sh = {shreg[6:0], sda_s};
                  next_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == irps_pkg::BIT_LAST) begin
                     next_wr = 1'b1;
                     next_state = irps_pkg::ST_WACK;
                  end
               end
            end
            irps_pkg::ST_RDATA: begin
               if (scl_rise) begin
                  next_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == irps_pkg::BIT_LAST) begin
                     next_ptr = ptr + 8'h01;
                     next_ph = irps_pkg::PH_WAIT;
                     next_state = irps_pkg::ST_RACK;
                  end
               end else if (scl_fall) begin
                  next_sh = {shreg[6:0], 1'b0};
                  next_oe = !shreg[6];
               end
            end
            irps_pkg::ST_RACK: begin
               if (scl_fall && ack_ph == irps_pkg::PH_WAIT) begin
                  next_oe = 1'b0;
                  next_ph = irps_pkg::PH_HELD;
               end else if (scl_rise && ack_ph == irps_pkg::PH_HELD) begin
                  next_m_ack = !sda_s;
                  next_ph = irps_pkg::PH_SAMPLED;
               end else if (scl_fall && ack_ph == irps_pkg::PH_SAMPLED) begin
                  next_ph = irps_pkg::PH_WAIT;
                  next_cnt = 3'h0;
                  if (m_ack) begin
                     next_sh = rd_data;
                     next_oe = !rd_data[7];
                     next_state = irps_pkg::ST_RDATA;
                  end else begin
                     next_oe = 1'b0;
                     next_state = irps_pkg::ST_IGNORE;
                  end
               end
            end
            irps_pkg::ST_IGNORE: begin
               // Waits for stop or repeated start with the line released
               next_oe = 1'b0;
            end
            default: begin
               next_state = irps_pkg::ST_IDLE;
               next_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state <= irps_pkg::ST_IDLE;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         ptr <= 8'h00;
         ack_ph <= irps_pkg::PH_WAIT;
         m_ack <= 1'b0;
         sda_oe_o <= 1'b0;
         sda_o <= 1'b0;
         wr_en <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         state <= next_state;
         bit_cnt <= next_cnt;
         shreg <= next_sh;
         ptr <= next_ptr;
         ack_ph <= next_ph;
         m_ack <= next_m_ack;
         sda_oe_o <= next_oe;
         sda_o <= 1'b0;
         wr_en <= next_wr;
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // Registers and link control muxes
   irps_regs u_regs (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .restore_n_i(restore_s),
      .wr_en_i(wr_en),
      .addr_i(ptr),
      .wr_data_i(shreg),
      .rd_data_o(rd_data),
      .sel_pins_i(sel_s),
      .en_pin_i(en_s),
      .active_input_o(active_input_o),
      .output_enable_o(output_enable_o),
      .output_current_level_o(output_current_level_o),
      .output_termination_on_o(output_termination_on_o)
   );

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_foreign;
      state == irps_pkg::ST_IGNORE |-> !sda_oe_o;
   endproperty
   a_foreign: assert property (p_foreign) else $error("drive while ignoring");
   property p_addr_ack;
      state == irps_pkg::ST_AACK && ack_ph == irps_pkg::PH_WAIT && scl_fall && quiet |=> sda_oe_o;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
   property p_ptr;
      $rose(state == irps_pkg::ST_PACK) |-> ptr == shreg;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer not latched");
   property p_wr;
      $rose(state == irps_pkg::ST_WACK) |-> wr_en;
   endproperty
   a_wr: assert property (p_wr) else $error("data byte not written");
   property p_msb;
      state == irps_pkg::ST_AACK && ack_ph == irps_pkg::PH_HELD && scl_fall && quiet && shreg[0]
         |=> state == irps_pkg::ST_RDATA && sda_oe_o == !$past(rd_data[7]);
   endproperty
   a_msb: assert property (p_msb) else $error("read msb wrong");
   property p_more;
      state == irps_pkg::ST_RACK && ack_ph == irps_pkg::PH_SAMPLED && scl_fall && quiet && m_ack
         |=> state == irps_pkg::ST_RDATA && shreg == $past(rd_data);
   endproperty
   a_more: assert property (p_more) else $error("next byte not sent");
   property p_nack;
      state == irps_pkg::ST_RACK && ack_ph == irps_pkg::PH_SAMPLED && scl_fall && !m_ack
         |=> !sda_oe_o ##1 !sda_oe_o;
   endproperty
   a_nack: assert property (p_nack) else $error("line kept after nack");

   c_write: cover property (wr_en);
   c_read_ack: cover property (state == irps_pkg::ST_RACK && ack_ph == irps_pkg::PH_SAMPLED && m_ack);
   c_resume: cover property (state == irps_pkg::ST_WACK ##[1:1000] start_det);
endmodule
`default_nettype wire

/* File: sim/irps_i2c_ctl.sv */
// Behavioural I2C bus controller that drives the register port of the switch.
// Assumes the bench resolves the open-drain data wire and feeds it back here.
`timescale 1ns/1ns
`default_nettype none
module irps_i2c_ctl (
   // Pacing clock
   input wire logic sys_clk_i,
   // Resolved data wire
   input wire logic sda_wire_i,
   // Controller lines, high means released
   output logic scl_o,
   output logic sda_o
);
   int half_cycles = 10; // Raised by the bench for a slow controller
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Wait on falling edges so changes never meet the sampling edge
   task automatic wait_clk(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // Start or repeated start: data falls while clock is high
   task automatic start();
      sda_o = 1'b1;
      wait_clk(half_cycles);
      scl_o = 1'b1;
      wait_clk(half_cycles);
      sda_o = 1'b0;
      wait_clk(half_cycles);
      scl_o = 1'b0;
      wait_clk(3);
   endtask
   // Stop: data rises while clock is high
   task automatic stop();
      sda_o = 1'b0;
      wait_clk(half_cycles);
      scl_o = 1'b1;
      wait_clk(half_cycles);
      sda_o = 1'b1;
      wait_clk(half_cycles);
   endtask
   // One bit; data held a few clocks past the clock fall
   task automatic bit_xfer(input logic b, output logic r);
      sda_o = b;
      wait_clk(half_cycles);
      scl_o = 1'b1;
      wait_clk(half_cycles);
      r = sda_wire_i;
      scl_o = 1'b0;
      wait_clk(3);
   endtask
   // Byte MSB first, then the acknowledge slot
   task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack_out);
      logic bv;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], bv);
         r[i] = bv;
      end
      bit_xfer(ack_in, ack_out);
   endtask
endmodule
`default_nettype wire

/* File: sim/irps_top_bench.sv */
// Self-checking bench for the I2C register port of the video link switch.
// Assumes the controller model in irps_i2c_ctl.sv; data wire has a pull-up.
`timescale 1ns/1ns
`default_nettype none
module irps_top_bench;
   logic sys_clk, rst_b, restore_n, en_pin, scl, ctl_sda, sda_out, sda_oe, out_en, out_cur, out_term;
   logic [1:0] strap, sel_pins, active;
   logic [7:0] r;
   logic a;
   int fail_count = 0;
   int num_checks = 0;
   wire sda_w = ctl_sda & (sda_oe ? sda_out : 1'b1); // Open drain with pull-up
   irps_top i_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_out),
      .sda_oe_o(sda_oe), .addr_strap_i(strap), .restore_defaults_n_i(restore_n),
      .chan_select_pins_i(sel_pins), .output_enable_pin_i(en_pin), .active_input_o(active),
      .output_enable_o(out_en), .output_current_level_o(out_cur), .output_termination_on_o(out_term));
   irps_i2c_ctl i_ctl (.sys_clk_i(sys_clk), .sda_wire_i(sda_w), .scl_o(scl), .sda_o(ctl_sda));
   // Clock, 50 ns period
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Compare a byte or a zero-extended flag
   task automatic chk(input logic [7:0] act, input logic [7:0] exp, input string what);
      num_checks++;
      if (act !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, act, exp);
      end
   endtask
   function automatic logic [7:0] adr(input logic rw, input logic [1:0] s);
      return {irps_pkg::ADDR_UPPER, s, rw};
   endfunction
   // Start, write address, pointer; leaves the bus held for Sr
   task automatic setptr(input logic [7:0] ptr);
      i_ctl.start();
      i_ctl.byte_xfer(adr(1'b0, strap), 1'b1, r, a);
      chk({7'h0, a}, 8'h00, "addr ack");
      i_ctl.byte_xfer(ptr, 1'b1, r, a);
      chk({7'h0, a}, 8'h00, "ptr ack");
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
      setptr(ptr);
      i_ctl.byte_xfer(data, 1'b1, r, a);
      chk({7'h0, a}, 8'h00, "data ack");
   endtask
   // Repeated start, read address, one byte closed by NACK
   task automatic rd(input logic [7:0] exp);
      i_ctl.start();
      i_ctl.byte_xfer(adr(1'b1, strap), 1'b1, r, a);
      chk({7'h0, a}, 8'h00, "read addr ack");
      i_ctl.byte_xfer(8'hff, 1'b1, r, a);
      chk(r, exp, "read byte");
   endtask
   // Stop, then the data line must be let go
   task automatic fin();
      i_ctl.stop();
      i_ctl.wait_clk(8);
      chk({7'h0, sda_oe}, 8'h00, "sda released");
   endtask
   task automatic t_defaults();
      setptr(irps_pkg::CHAN_SEL_OFS);
      rd(8'h00);
      fin();
      setptr(irps_pkg::OUT_CTL_OFS);
      rd(8'h07);
      fin();
      chk({7'h0, out_cur}, 8'h01, "current");
      chk({7'h0, out_term}, 8'h01, "termination");
      chk({6'h0, active}, 8'h03, "active from pins");
      en_pin = 1'b1;
      i_ctl.wait_clk(8);
      chk({7'h0, out_en}, 8'h01, "enable from pin");
      en_pin = 1'b0;
      i_ctl.wait_clk(8);
      chk({7'h0, out_en}, 8'h00, "enable from pin");
   endtask
   task automatic t_output_ctl();
      wr(irps_pkg::OUT_CTL_OFS, 8'hfc);
      rd(8'h0c);
      fin();
      chk({7'h0, out_en}, 8'h01, "enable bit");
      chk({7'h0, out_cur}, 8'h00, "current");
      chk({7'h0, out_term}, 8'h00, "termination");
      en_pin = 1'b1;
      wr(irps_pkg::OUT_CTL_OFS, 8'h0b);
      fin();
      chk({7'h0, out_en}, 8'h00, "enable bit");
      chk({7'h0, out_term}, 8'h01, "termination");
   endtask
   // Channel writes chained by repeated starts without stop
   task automatic t_channel();
      for (int ch = 0; ch < 4; ch++) begin
         wr(irps_pkg::CHAN_SEL_OFS, 8'h04 | 8'(ch));
         chk({6'h0, active}, 8'(ch), "active from field");
      end
      fin();
      sel_pins = 2'b01;
      wr(irps_pkg::CHAN_SEL_OFS, 8'h03);
      fin();
      chk({6'h0, active}, 8'h01, "active from pins");
   endtask
   // Slow controller reads three bytes with ACK between them
   task automatic t_burst();
      i_ctl.half_cycles = 25;
      setptr(irps_pkg::CHAN_SEL_OFS);
      i_ctl.start();
      i_ctl.byte_xfer(adr(1'b1, strap), 1'b1, r, a);
      i_ctl.byte_xfer(8'hff, 1'b0, r, a);
      chk(r, 8'h03, "burst 0");
      i_ctl.byte_xfer(8'hff, 1'b0, r, a);
      chk(r, 8'h0b, "burst 1");
      i_ctl.byte_xfer(8'hff, 1'b1, r, a);
      chk(r, 8'h00, "burst 2");
      fin();
      i_ctl.half_cycles = 10;
   endtask
   task automatic t_addr();
      i_ctl.start();
      i_ctl.byte_xfer(adr(1'b0, ~strap), 1'b1, r, a);
      chk({7'h0, a}, 8'h01, "foreign address");
      fin();
   endtask
   task automatic t_restore();
      wr(irps_pkg::OUT_CTL_OFS, 8'h08);
      fin();
      restore_n = 1'b0;
      i_ctl.wait_clk(10);
      restore_n = 1'b1;
      i_ctl.wait_clk(6);
      chk({7'h0, out_term}, 8'h01, "restored");
      setptr(irps_pkg::OUT_CTL_OFS);
      rd(8'h07);
      fin();
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence, inputs change on falling edges
   initial begin
      rst_b = 1'b0;
      restore_n = 1'b1;
      en_pin = 1'b0;
      strap = 2'b10;
      sel_pins = 2'b11;
      repeat (5) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_defaults();
      t_output_ctl();
      t_channel();
      t_burst();
      t_addr();
      t_restore();
      final_report();
   end
   // Watchdog, several times the expected run
   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      final_report();
   end
endmodule
`default_nettype wire
